// File: rtl/tuning_regs_defs.svh
`ifndef TUNING_REGS_DEFS_SVH
`define TUNING_REGS_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_WALK_CACHE_CONTROL 20'h08E00
`define OFS_TRANSACTION_PRIORITY_VALUES 20'h08E04
`define OFS_BUILD_CONFIGURATION_INFO 20'h08E08
`define OFS_UARCH_PERMIT 20'h08E18

// ****************************************
// walk cache control fields
// ****************************************
`define WCC_S2_LVL1_POS 13
`define WCC_S2_LVL0_POS 12
`define WCC_S1_LVL3_POS 11
`define WCC_S1_LVL2_POS 10
`define WCC_S1_LVL1_POS 9
`define WCC_S1_LVL0_POS 8
`define WCC_AUX_LO_MSB 7
`define WCC_STORED_MSB 15
`define WCC_RESET 16'h0000

// ****************************************
// priority value fields
// ****************************************
`define QOS_SYNC_LSB 24
`define QOS_INTR_LSB 20
`define QUEUE_ACCESS_PRIORITY_LSB 16
`define QOS_WALK3_LSB 12
`define QOS_WALK2_LSB 8
`define QOS_WALK1_LSB 4
`define QOS_WALK0_LSB 0
`define QOS_USED_MSB 27
`define QOS_RESET 28'h0000000

// ****************************************
// configuration info fields
// ****************************************
`define CFG_SLOTS_LSB 4
`define CFG_SLOTS_MSB 15

// ****************************************
// permit register field
// ****************************************
`define PERMIT_UARCH_POS 0

`endif

// File: rtl/tuning_regs_pkg.sv
package tuning_regs_pkg;

  typedef logic [3:0] qos_t;

  typedef enum logic [3:0] {
    TXN_WALK = 4'h1,
    TXN_SYNC = 4'h2,
    TXN_INTR = 4'h4,
    TXN_QUEUE = 4'h8
  } txn_kind_e;

endpackage

// File: rtl/two_flop_sync.sv
`timescale 1ns/100ps
module two_flop_sync (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule

// File: rtl/qos_select.sv
`timescale 1ns/100ps
`include "tuning_regs_defs.svh"
module qos_select
  import tuning_regs_pkg::*;
(
  input wire logic [`QOS_USED_MSB:0] qos_fields,
  input wire txn_kind_e txn_kind,
  input wire logic [1:0] walk_priority,
  output qos_t axqos
);
  qos_t walk_qos;

  // only the transaction's own kind and priority matter
  always_comb begin
    unique case (walk_priority)
      2'h3: walk_qos = qos_fields[`QOS_WALK3_LSB +: 4];
      2'h2: walk_qos = qos_fields[`QOS_WALK2_LSB +: 4];
      2'h1: walk_qos = qos_fields[`QOS_WALK1_LSB +: 4];
      2'h0: walk_qos = qos_fields[`QOS_WALK0_LSB +: 4];
    endcase
  end

  always_comb begin
    unique case (txn_kind)
      TXN_WALK: axqos = walk_qos;
      TXN_SYNC: axqos = qos_fields[`QOS_SYNC_LSB +: 4];
      TXN_INTR: axqos = qos_fields[`QOS_INTR_LSB +: 4];
      TXN_QUEUE: axqos = qos_fields[`QUEUE_ACCESS_PRIORITY_LSB +: 4];
      default: axqos = 4'h0;
    endcase
  end
endmodule

// File: rtl/tuning_config_regs.sv
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`include "tuning_regs_defs.svh"
// Function
// - a 1 in the stage 2 level 1 or level 0 disable bit turns that walk cache level off.
// - control bits 11 to 8 turn off stage 1 walk cache levels 3, 2, 1 and 0 when set.
// - master-port AxQOS comes from the priority register field for the transaction kind.
// - bits 27 to 24 give AxQOS of sync completion messages.
// - bits 23 to 20 give AxQOS of interrupt message writes.
// - bits 19 to 16 give AxQOS of queue memory accesses.
// - table walks take AxQOS from bits 15:12 down to 3:0 by node priority 3 down to 0.
// - AxQOS depends only on the transaction's own kind and priority.
// - without the non-secure permit, non-secure priority register reads give zero, writes drop.
// - priority register writes land only while both translation enables are 0.
// - configuration register is read-only and reads zero to non-secure without the permit.
// - configuration bits 15 to 4 report the shared slot count from the build parameter.
// - the non-secure permit bit resets to the secure override input's value.
module tuning_config_regs
  import tuning_regs_pkg::*;
#(
  parameter logic [11:0] SLOT_COUNT_PARAMETER = 12'h010
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [19:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_nonsecure,
  output logic [31:0] reg_rdata,
  input wire logic sec_override,
  input wire logic translation_enable_s,
  input wire logic translation_enable_ns,
  input wire logic txn_valid,
  input wire txn_kind_e txn_kind,
  input wire logic [1:0] walk_priority,
  output logic axqos_valid,
  output qos_t axqos,
  output logic s2_lvl1_walkcache_off,
  output logic s2_lvl0_walkcache_off,
  output logic s1_lvl3_walkcache_off,
  output logic s1_lvl2_walkcache_off,
  output logic s1_lvl1_walkcache_off,
  output logic s1_lvl0_walkcache_off,
  output logic nonsecure_uarch_permit
);

  // ****************************************
  // override strap capture
  // ****************************************
  logic sec_override_sync;
  logic [1:0] strap_cnt_r;
  logic [1:0] strap_cnt_nxt;

  two_flop_sync u_override_sync (
    .mclk(mclk),
    .resetn(resetn),
    .async_in(sec_override),
    .sync_out(sec_override_sync)
  );

  // ****************************************
  // register state
  // ****************************************
  logic [`WCC_STORED_MSB:0] walk_cache_control_r;
  logic [`WCC_STORED_MSB:0] walk_cache_control_nxt;
  logic [`QOS_USED_MSB:0] transaction_priority_values_r;
  logic [`QOS_USED_MSB:0] transaction_priority_values_nxt;
  logic [11:0] shared_slot_count_r;
  logic [11:0] shared_slot_count_nxt;
  logic permit_r;
  logic permit_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic ns_blocked;
  logic translation_off;
  logic hit_wcc;
  logic hit_qos;
  logic hit_cfg;
  logic hit_permit;

  always_comb begin
    // permit gates the control, priority and configuration registers for non-secure masters
    ns_blocked = reg_nonsecure && !permit_r;
    translation_off = !translation_enable_s && !translation_enable_ns;
    hit_wcc = (reg_addr == `OFS_WALK_CACHE_CONTROL);
    hit_qos = (reg_addr == `OFS_TRANSACTION_PRIORITY_VALUES);
    hit_cfg = (reg_addr == `OFS_BUILD_CONFIGURATION_INFO);
    hit_permit = (reg_addr == `OFS_UARCH_PERMIT);
  end

  always_comb begin
    walk_cache_control_nxt = walk_cache_control_r;
    transaction_priority_values_nxt = transaction_priority_values_r;
    shared_slot_count_nxt = shared_slot_count_r;
    permit_nxt = permit_r;
    strap_cnt_nxt = strap_cnt_r;
    if (strap_cnt_r != 2'h3) begin
      strap_cnt_nxt = strap_cnt_r + 2'h1;
      // sync stages still hold their reset zeros until the second edge after release
      if (strap_cnt_r == 2'h2) begin
        permit_nxt = sec_override_sync;
        shared_slot_count_nxt = SLOT_COUNT_PARAMETER;
      end
    end else if (reg_write) begin
      if (hit_wcc && !ns_blocked) begin
        walk_cache_control_nxt = reg_wdata[`WCC_STORED_MSB:0];
      end
      // reserved bits above the used fields are never stored
      if (hit_qos && !ns_blocked && translation_off) begin
        transaction_priority_values_nxt = reg_wdata[`QOS_USED_MSB:0];
      end
      // secure-only; non-secure writes are ignored
      if (hit_permit && !reg_nonsecure) begin
        permit_nxt = reg_wdata[`PERMIT_UARCH_POS];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      walk_cache_control_r <= `WCC_RESET;
      transaction_priority_values_r <= `QOS_RESET;
      shared_slot_count_r <= 12'h000;
      permit_r <= 1'b0;
      strap_cnt_r <= 2'h0;
    end else begin
      walk_cache_control_r <= walk_cache_control_nxt;
      transaction_priority_values_r <= transaction_priority_values_nxt;
      shared_slot_count_r <= shared_slot_count_nxt;
      permit_r <= permit_nxt;
      strap_cnt_r <= strap_cnt_nxt;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_read) begin
      if (hit_wcc && !ns_blocked) begin
        rdata_nxt[`WCC_STORED_MSB:0] = walk_cache_control_r;
      end else if (hit_qos && !ns_blocked) begin
        rdata_nxt[`QOS_USED_MSB:0] = transaction_priority_values_r;
      end else if (hit_cfg && !ns_blocked) begin
        rdata_nxt[`CFG_SLOTS_MSB:`CFG_SLOTS_LSB] = shared_slot_count_r;
      end else if (hit_permit && !reg_nonsecure) begin
        rdata_nxt[`PERMIT_UARCH_POS] = permit_r;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************
  // master-port priority
  // ****************************************
  qos_t axqos_sel;
  qos_t axqos_r;
  qos_t axqos_nxt;
  logic axqos_valid_r;
  logic axqos_valid_nxt;

  qos_select u_qos_select (
    .qos_fields(transaction_priority_values_r),
    .txn_kind(txn_kind),
    .walk_priority(walk_priority),
    .axqos(axqos_sel)
  );

  // value goes only to the bus; no internal arbitration reads it
  always_comb begin
    axqos_nxt = axqos_r;
    axqos_valid_nxt = txn_valid;
    if (txn_valid) begin
      axqos_nxt = axqos_sel;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      axqos_r <= 4'h0;
      axqos_valid_r <= 1'b0;
    end else begin
      axqos_r <= axqos_nxt;
      axqos_valid_r <= axqos_valid_nxt;
    end
  end

  assign axqos = axqos_r;
  assign axqos_valid = axqos_valid_r;

  // ****************************************
  // walk cache disables
  // ****************************************
  // aux bits are stored and read back but steer nothing
  assign s2_lvl1_walkcache_off = walk_cache_control_r[`WCC_S2_LVL1_POS];
  assign s2_lvl0_walkcache_off = walk_cache_control_r[`WCC_S2_LVL0_POS];
  assign s1_lvl3_walkcache_off = walk_cache_control_r[`WCC_S1_LVL3_POS];
  assign s1_lvl2_walkcache_off = walk_cache_control_r[`WCC_S1_LVL2_POS];
  assign s1_lvl1_walkcache_off = walk_cache_control_r[`WCC_S1_LVL1_POS];
  assign s1_lvl0_walkcache_off = walk_cache_control_r[`WCC_S1_LVL0_POS];
  assign nonsecure_uarch_permit = permit_r;

endmodule

// File: testbench/tuning_config_regs_chk.sv
`timescale 1ns/100ps
module tuning_config_regs_chk
  import tuning_regs_pkg::*;
#(
  parameter logic [11:0] SLOT_COUNT_PARAMETER = 12'h010
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [19:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_nonsecure,
  input wire logic [31:0] reg_rdata,
  input wire logic sec_override,
  input wire logic translation_enable_s,
  input wire logic translation_enable_ns,
  input wire logic txn_valid,
  input wire txn_kind_e txn_kind,
  input wire logic [1:0] walk_priority,
  input wire logic axqos_valid,
  input wire qos_t axqos,
  input wire logic s2_lvl1_walkcache_off,
  input wire logic s2_lvl0_walkcache_off,
  input wire logic s1_lvl3_walkcache_off,
  input wire logic s1_lvl2_walkcache_off,
  input wire logic s1_lvl1_walkcache_off,
  input wire logic s1_lvl0_walkcache_off,
  input wire logic nonsecure_uarch_permit
);
  // ********
  // shadow priority register: only writes that may land
  // ********
  logic [27:0] sh_r, sh_nxt;
  logic [5:0] wc_w, wc_o;
  logic [3:0] exp_q;
  logic ok_w;
  assign ok_w = !reg_nonsecure || nonsecure_uarch_permit;
  assign wc_w = reg_wdata[13:8];
  assign wc_o = {s2_lvl1_walkcache_off, s2_lvl0_walkcache_off, s1_lvl3_walkcache_off,
    s1_lvl2_walkcache_off, s1_lvl1_walkcache_off, s1_lvl0_walkcache_off};
  always_comb begin
    sh_nxt = sh_r;
    if (reg_write && reg_addr == 20'h08E04 && ok_w && !translation_enable_s
        && !translation_enable_ns) begin
      sh_nxt = reg_wdata[27:0];
    end
    case (txn_kind)
      TXN_SYNC: exp_q = sh_r[27:24];
      TXN_INTR: exp_q = sh_r[23:20];
      TXN_QUEUE: exp_q = sh_r[19:16];
      default: exp_q = sh_r[walk_priority*4 +: 4];
    endcase
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) sh_r <= 28'h0;
    else sh_r <= sh_nxt;
  end
  // ********
  // properties
  // ********
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_valid; txn_valid |=> axqos_valid; endproperty
  a_valid: assert property (p_valid) else $error("qos valid missing");
  property p_sync; txn_valid && txn_kind == TXN_SYNC |=> axqos == $past(exp_q); endproperty
  a_sync: assert property (p_sync) else $error("sync qos wrong");
  property p_msg;
    txn_valid && (txn_kind == TXN_INTR || txn_kind == TXN_QUEUE) |=> axqos == $past(exp_q);
  endproperty
  a_msg: assert property (p_msg) else $error("message qos wrong");
  property p_walk; txn_valid && txn_kind == TXN_WALK |=> axqos == $past(exp_q); endproperty
  a_walk: assert property (p_walk) else $error("walk qos wrong");
  property p_wc; reg_write && reg_addr == 20'h08E00 && ok_w |=> wc_o == $past(wc_w); endproperty
  a_wc: assert property (p_wc) else $error("walk cache bits wrong");
  property p_nsrd;
    reg_read && reg_nonsecure && !nonsecure_uarch_permit && reg_addr[19:4] == 16'h08E0
      |=> reg_rdata == 32'h0;
  endproperty
  a_nsrd: assert property (p_nsrd) else $error("nonsecure read not zero");
  property p_cfg;
    reg_read && reg_addr == 20'h08E08 && ok_w
      |=> reg_rdata == {16'h0, SLOT_COUNT_PARAMETER, 4'h0};
  endproperty
  a_cfg: assert property (p_cfg) else $error("slot count wrong");
  property p_qos; reg_read && reg_addr == 20'h08E04 && ok_w |=> reg_rdata == {4'h0, $past(sh_r)};
  endproperty
  a_qos: assert property (p_qos) else $error("priority readback wrong");
  // strap lands on the third edge after release, seen one edge later
  property p_permit; $rose(resetn) |-> ##3 nonsecure_uarch_permit == $past(sec_override, 2);
  endproperty
  a_permit: assert property (p_permit) else $error("permit reset wrong");
  c_walk: cover property (txn_valid && txn_kind == TXN_WALK && walk_priority == 2'h3);
  c_drop: cover property (reg_write && reg_addr == 20'h08E04 && translation_enable_s);
  c_nsrd: cover property (reg_read && reg_nonsecure && !nonsecure_uarch_permit);
endmodule

bind tuning_config_regs tuning_config_regs_chk #(.SLOT_COUNT_PARAMETER(SLOT_COUNT_PARAMETER))
  tuning_config_regs_chk_i (.*);

// File: testbench/tuning_config_regs_test.sv
`timescale 1ns/100ps
module tuning_config_regs_test;
  import tuning_regs_pkg::*;
  localparam logic [11:0] SLOTS = 12'h0A5;
  logic mclk = 1'h0, resetn = 1'h0, reg_write = 1'h0, reg_read = 1'h0, reg_nonsecure = 1'h0;
  logic sec_override = 1'h1, translation_enable_s = 1'h0, translation_enable_ns = 1'h0;
  logic txn_valid = 1'h0, axqos_valid, nonsecure_uarch_permit, prm_m;
  logic s2_lvl1_walkcache_off, s2_lvl0_walkcache_off, s1_lvl3_walkcache_off;
  logic s1_lvl2_walkcache_off, s1_lvl1_walkcache_off, s1_lvl0_walkcache_off;
  logic [19:0] reg_addr = 20'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, qos_m, ctl_m, d;
  logic [1:0] walk_priority = 2'h0;
  txn_kind_e txn_kind = TXN_WALK;
  qos_t axqos;
  integer fails = 0, cmp_count = 0, seed = 32'hC387C980, i, p;
  tuning_config_regs #(.SLOT_COUNT_PARAMETER(SLOTS)) tuning_config_regs_i (.*);
  // ********
  // model and bus tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] dat, input logic ns);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_nonsecure <= ns;
    reg_write <= 1'h1;
    @(posedge mclk);
    reg_write <= 1'h0;
    if (a == 20'h08E00 && (!ns || prm_m)) ctl_m = dat & 32'h0000FFFF;
    if (a == 20'h08E04 && (!ns || prm_m) && !translation_enable_s && !translation_enable_ns)
      qos_m = dat & 32'h0FFFFFFF;
    if (a == 20'h08E18 && !ns) prm_m = dat[0];
  endtask
  task automatic rd(input logic [19:0] a, input logic ns);
    logic [31:0] e;
    e = 32'h0;
    if (!ns || prm_m) begin
      if (a == 20'h08E00) e = ctl_m;
      if (a == 20'h08E04) e = qos_m;
      if (a == 20'h08E08) e = {16'h0, SLOTS, 4'h0};
    end
    if (a == 20'h08E18 && !ns) e = {31'h0, prm_m};
    @(posedge mclk);
    reg_addr <= a;
    reg_nonsecure <= ns;
    reg_read <= 1'h1;
    @(posedge mclk);
    reg_read <= 1'h0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic txn(input txn_kind_e k, input logic [1:0] pr);
    logic [3:0] e;
    e = k == TXN_SYNC ? qos_m[27:24] : k == TXN_INTR ? qos_m[23:20] :
      k == TXN_QUEUE ? qos_m[19:16] : qos_m[pr*4 +: 4];
    @(posedge mclk);
    txn_valid <= 1'h1;
    txn_kind <= k;
    walk_priority <= pr;
    @(posedge mclk);
    txn_valid <= 1'h0;
    #1 chk({27'h0, axqos_valid, axqos}, {27'h0, 1'h1, e});
  endtask
  task automatic rst(input logic ov);
    @(posedge mclk);
    resetn <= 1'h0;
    sec_override <= ov;
    repeat (10) @(posedge mclk);
    resetn <= 1'h1;
    qos_m = 32'h0;
    ctl_m = 32'h0;
    prm_m = ov;
    repeat (3) @(posedge mclk);
    #1 chk({31'h0, nonsecure_uarch_permit}, {31'h0, ov});
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ********
  // sequence; watchdog cuts a hang short
  // ********
  initial forever #25 mclk = ~mclk;
  initial begin
    repeat (5000) @(posedge mclk);
    $display("Error at %0t: watchdog expired", $time);
    fails++;
    report_and_stop;
  end
  initial begin
    rst(1'h1);
    rd(20'h08E08, 1'h0);
    wr(20'h08E08, 32'hFFFFFFFF, 1'h0);
    rd(20'h08E08, 1'h0);
    rd(20'h08E0C, 1'h0);
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      // no invalidate register here; enables rise only to see writes dropped
      translation_enable_s <= (i == 2);
      translation_enable_ns <= (i == 3);
      d = $random(seed);
      wr(20'h08E04, d, 1'h0);
      rd(20'h08E04, 1'h0);
      txn(TXN_SYNC, 2'h3);
      txn(TXN_INTR, 2'h2);
      txn(TXN_QUEUE, 2'h1);
      for (p = 0; p < 4; p++) txn(TXN_WALK, p[1:0]);
      d = $random(seed) & 32'hFFFFFF00;
      wr(20'h08E00, d, 1'h0);
      rd(20'h08E00, 1'h0);
      chk({26'h0, s2_lvl1_walkcache_off, s2_lvl0_walkcache_off, s1_lvl3_walkcache_off,
        s1_lvl2_walkcache_off, s1_lvl1_walkcache_off, s1_lvl0_walkcache_off},
        {26'h0, ctl_m[13:8]});
    end
    @(posedge mclk);
    translation_enable_s <= 1'h0;
    translation_enable_ns <= 1'h0;
    wr(20'h08E04, 32'h0A5A5A5A, 1'h1);
    rd(20'h08E04, 1'h1);
    wr(20'h08E18, 32'h0, 1'h0);
    #1 chk({31'h0, nonsecure_uarch_permit}, 32'h0);
    wr(20'h08E18, 32'h00000001, 1'h1);
    rd(20'h08E18, 1'h0);
    wr(20'h08E04, 32'h01234567, 1'h1);
    rd(20'h08E04, 1'h1);
    rd(20'h08E08, 1'h1);
    rd(20'h08E04, 1'h0);
    txn(TXN_QUEUE, 2'h0);
    rst(1'h0);
    rd(20'h08E04, 1'h0);
    report_and_stop;
  end
endmodule
